// ### inc/compare_capture_pkg.sv
package compare_capture_pkg;

  // wishbone geometry
  localparam int WB_DW = 32;
  localparam int WB_AW = 8;
  localparam int WB_SW = WB_DW / 8;
  localparam int BYTE_W = 8;

  // register byte offsets
  localparam logic [WB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [WB_AW-1:0] COUNT_OFS = 8'h04;
  localparam logic [WB_AW-1:0] GRC_OFS = 8'h08;
  localparam logic [WB_AW-1:0] STAT_OFS = 8'h0c;
  localparam logic [WB_AW-1:0] MASK_OFS = 8'h10;
  localparam logic [WB_AW-1:0] PIN_OFS = 8'h14;

  // control register layout
  localparam int FLD_W = 4;
  localparam int MODE_BIT = 3;
  localparam int INIT_BIT = 2;
  localparam int ACT_HI_BIT = 1;
  localparam int ACT_LO_BIT = 0;
  localparam int BUF_BIT = 4;
  localparam int RUN_BIT = 5;

  // pin status register layout
  localparam int PIN_LVL_BIT = 0;
  localparam int PIN_OEN_BIT = 1;
  localparam int PIN_IN_BIT = 2;

  // event status / mask layout
  localparam int EV_CMP = 0;
  localparam int EV_CAP = 1;
  localparam int EV_W = 2;

  // reset values
  localparam logic [FLD_W-1:0] PIN_CTL_RST = 4'h0;
  localparam logic [EV_W-1:0] STAT_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;

  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_RISE,
    SRC_FALL,
    SRC_BOTH,
    SRC_CH4
  } cap_src_type;

  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_LOW,
    OUT_HIGH,
    OUT_TOGGLE
  } out_act_type;

endpackage

// ### hdl/level_edge_detect.sv
`timescale 1ns/1ps
module level_edge_detect
  import compare_capture_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // sampled levels and their edges
  input wire logic [WIDTH-1:0] sig_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  typedef struct packed {
    logic armed;
    logic [WIDTH-1:0] prev;
  } edge_state_type;

  edge_state_type st;
  edge_state_type next_st;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("level_edge_detect: WIDTH must be at least 1");
    end
  endgenerate

  // armed blocks a false edge from the unknown level before reset release
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign rise_o[i] = st.armed & sig_i[i] & ~st.prev[i];
      assign fall_o[i] = st.armed & ~sig_i[i] & st.prev[i];
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.armed = 1'b1;
    next_st.prev = sig_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### hdl/event_status.sv
`timescale 1ns/1ps
module event_status
  import compare_capture_pkg::*;
#(
  parameter int EVW = EV_W
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // events from the block
  input wire logic [EVW-1:0] set_i,
  // software access
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [EVW-1:0] wdat_i,
  // state
  output logic [EVW-1:0] status_o,
  output logic [EVW-1:0] mask_o,
  output logic irq_o
);

  typedef struct packed {
    logic [EVW-1:0] status;
    logic [EVW-1:0] mask;
    logic irq;
  } ev_state_type;

  ev_state_type st;
  ev_state_type next_st;
  logic [EVW-1:0] next_status;

  generate
    if (EVW != EV_W) begin : g_bad_width
      $error("event_status: EVW must match the event layout");
    end
  endgenerate

  // a new event beats a write-one-to-clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < EVW; i++) begin : g_bit
      assign next_status[i] = set_i[i] |
        (st.status[i] & ~(clr_wr_i & wdat_i[i]));
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.status = next_status;
    if (mask_wr_i) begin
      next_st.mask = wdat_i;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.status <= STAT_RST;
      st.mask <= MASK_RST;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign mask_o = st.mask;
  assign irq_o = st.irq;

endmodule

// ### hdl/compare_capture_pin_control.sv
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - field bit3 low: compare; bit2 initial level; low bits 00 disable pin
// - compare, low bits 01: drive pin low on counter match
// - compare, low bits 10: drive pin high on counter match
// - compare, low bits 11: invert pin level on each counter match
// - field 1000: capture on each rising pin edge
// - field 1001: capture on each falling pin edge
// - field 101x: capture on both pin edges
// - field 11xx: capture on each channel 4 count step
// - buffer mode on: no capture and no compare event at all
module compare_capture_pin_control
  import compare_capture_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [WB_SW-1:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // channel 3 pin c
  input wire logic ch3_pin_c_i,
  output logic ch3_pin_c_o,
  output logic ch3_pin_c_oe_n_o,
  // channel 4 count step, one cycle per count up or down
  input wire logic ch4_count_pulse_i,
  // interrupt
  output logic irq_o
);

  typedef struct packed {
    logic ack;
    logic [WB_DW-1:0] rdata;
    logic [FLD_W-1:0] pin_ctl;
    logic buf_en;
    logic run;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] grc;
    logic pin_level;
    logic oe_n;
  } main_state_type;

  main_state_type st;
  main_state_type next_st;

  generate
    if (CNT_W < 2 || CNT_W > WB_DW) begin : g_bad_width
      $error("compare_capture_pin_control: CNT_W out of range");
    end
  endgenerate

  function automatic logic [WB_DW-1:0] merge_bytes(
    input logic [WB_DW-1:0] old,
    input logic [WB_DW-1:0] dat,
    input logic [WB_SW-1:0] sel
  );
    logic [WB_DW-1:0] res;
    res = old;
    for (int b = 0; b < WB_SW; b++) begin
      if (sel[b]) begin
        res[b*BYTE_W +: BYTE_W] = dat[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  logic req;
  logic wr;
  logic hit_ctrl;
  logic hit_count;
  logic hit_grc;
  logic hit_stat;
  logic hit_mask;
  logic hit_pin;
  logic wr_ctrl;
  logic [WB_DW-1:0] ctrl_rd;
  logic [WB_DW-1:0] count_rd;
  logic [WB_DW-1:0] grc_rd;
  logic [WB_DW-1:0] stat_rd;
  logic [WB_DW-1:0] mask_rd;
  logic [WB_DW-1:0] pin_rd;
  logic [WB_DW-1:0] ctrl_w;
  logic [WB_DW-1:0] count_w;
  logic [WB_DW-1:0] grc_w;
  logic [WB_DW-1:0] rd_mux;
  cap_src_type src;
  out_act_type act;
  logic pin_rise;
  logic pin_fall;
  logic cap_trig;
  logic cap_hit;
  logic cmp_hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic irq;

  level_edge_detect #(
    .WIDTH(1)
  ) u_pin_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(ch3_pin_c_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // writes commit on the edge where the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & st.ack;
  assign hit_ctrl = (wb_adr_i == CTRL_OFS);
  assign hit_count = (wb_adr_i == COUNT_OFS);
  assign hit_grc = (wb_adr_i == GRC_OFS);
  assign hit_stat = (wb_adr_i == STAT_OFS);
  assign hit_mask = (wb_adr_i == MASK_OFS);
  assign hit_pin = (wb_adr_i == PIN_OFS);
  assign wr_ctrl = wr & hit_ctrl;

  // field decode
  always_comb begin
    src = SRC_NONE;
    act = OUT_OFF;
    if (st.pin_ctl[MODE_BIT]) begin
      if (st.pin_ctl[INIT_BIT]) begin
        src = SRC_CH4;
      end else if (st.pin_ctl[ACT_HI_BIT]) begin
        src = SRC_BOTH;
      end else if (st.pin_ctl[ACT_LO_BIT]) begin
        src = SRC_FALL;
      end else begin
        src = SRC_RISE;
      end
    end else begin
      case (st.pin_ctl[ACT_HI_BIT:ACT_LO_BIT])
        2'h1: act = OUT_LOW;
        2'h2: act = OUT_HIGH;
        2'h3: act = OUT_TOGGLE;
        default: act = OUT_OFF;
      endcase
    end
  end

  always_comb begin
    case (src)
      SRC_RISE: cap_trig = pin_rise;
      SRC_FALL: cap_trig = pin_fall;
      SRC_BOTH: cap_trig = pin_rise | pin_fall;
      SRC_CH4: cap_trig = ch4_count_pulse_i;
      default: cap_trig = 1'b0;
    endcase
  end

  // buffer use of register c silences both event kinds
  assign cap_hit = cap_trig & ~st.buf_en;
  assign cmp_hit = st.run & ~st.buf_en & ~st.pin_ctl[MODE_BIT] &
    (st.count == st.grc);
  assign ev_set[EV_CMP] = cmp_hit;
  assign ev_set[EV_CAP] = cap_hit;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[FLD_W-1:0] = st.pin_ctl;
    ctrl_rd[BUF_BIT] = st.buf_en;
    ctrl_rd[RUN_BIT] = st.run;
    count_rd = '0;
    count_rd[CNT_W-1:0] = st.count;
    grc_rd = '0;
    grc_rd[CNT_W-1:0] = st.grc;
    stat_rd = '0;
    stat_rd[EV_W-1:0] = status;
    mask_rd = '0;
    mask_rd[EV_W-1:0] = mask;
    pin_rd = '0;
    pin_rd[PIN_LVL_BIT] = st.pin_level;
    pin_rd[PIN_OEN_BIT] = st.oe_n;
    pin_rd[PIN_IN_BIT] = ch3_pin_c_i;
    ctrl_w = merge_bytes(ctrl_rd, wb_dat_i, wb_sel_i);
    count_w = merge_bytes(count_rd, wb_dat_i, wb_sel_i);
    grc_w = merge_bytes(grc_rd, wb_dat_i, wb_sel_i);
    // unmapped addresses still ack and read as zero
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_count) begin
      rd_mux = count_rd;
    end else if (hit_grc) begin
      rd_mux = grc_rd;
    end else if (hit_stat) begin
      rd_mux = stat_rd;
    end else if (hit_mask) begin
      rd_mux = mask_rd;
    end else if (hit_pin) begin
      rd_mux = pin_rd;
    end
  end

  always_comb begin
    next_st = st;
    next_st.ack = req & ~st.ack;
    next_st.rdata = '0;
    if (req & ~st.ack) begin
      next_st.rdata = rd_mux;
    end
    if (st.run) begin
      next_st.count = CNT_W'(st.count + 1'b1);
    end
    if (cmp_hit) begin
      case (act)
        OUT_LOW: next_st.pin_level = 1'b0;
        OUT_HIGH: next_st.pin_level = 1'b1;
        OUT_TOGGLE: next_st.pin_level = ~st.pin_level;
        default: next_st.pin_level = st.pin_level;
      endcase
    end
    // a new compare setting reloads the initial level over any match
    if (wr_ctrl) begin
      next_st.pin_ctl = ctrl_w[FLD_W-1:0];
      next_st.buf_en = ctrl_w[BUF_BIT];
      next_st.run = ctrl_w[RUN_BIT];
      if (!ctrl_w[MODE_BIT]) begin
        next_st.pin_level = ctrl_w[INIT_BIT];
      end
    end
    if (wr & hit_count) begin
      next_st.count = count_w[CNT_W-1:0];
    end
    if (wr & hit_grc) begin
      next_st.grc = grc_w[CNT_W-1:0];
    end
    // hardware capture beats a software write of register c
    if (cap_hit) begin
      next_st.grc = st.count;
    end
    next_st.oe_n = next_st.pin_ctl[MODE_BIT] |
      ~(next_st.pin_ctl[ACT_HI_BIT] | next_st.pin_ctl[ACT_LO_BIT]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.pin_ctl <= PIN_CTL_RST;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  event_status #(
    .EVW(EV_W)
  ) u_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ev_set),
    .clr_wr_i(wr & hit_stat & wb_sel_i[0]),
    .mask_wr_i(wr & hit_mask & wb_sel_i[0]),
    .wdat_i(wb_dat_i[EV_W-1:0]),
    .status_o(status),
    .mask_o(mask),
    .irq_o(irq)
  );

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign ch3_pin_c_o = st.pin_level;
  assign ch3_pin_c_oe_n_o = st.oe_n;
  assign irq_o = irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_captured;
    ##1 (st.grc == $past(st.count)) && status[EV_CAP];
  endsequence

  sequence s_level_is(logic lvl);
    ##1 (ch3_pin_c_o == lvl);
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_init_level: assert property (
    wr_ctrl && !ctrl_w[MODE_BIT] |=>
      ch3_pin_c_o == $past(ctrl_w[INIT_BIT]))
    else $error("initial pin level not loaded");
  a_pin_disabled: assert property (
    (act == OUT_OFF) == ch3_pin_c_oe_n_o)
    else $error("pin drive does not follow field");
  a_match_low: assert property (
    cmp_hit && act == OUT_LOW && !wr_ctrl |-> s_level_is(1'b0))
    else $error("pin not low after match");
  a_match_high: assert property (
    cmp_hit && act == OUT_HIGH && !wr_ctrl |-> s_level_is(1'b1))
    else $error("pin not high after match");
  a_match_toggle: assert property (
    cmp_hit && act == OUT_TOGGLE && !wr_ctrl |=>
      ch3_pin_c_o != $past(ch3_pin_c_o))
    else $error("pin did not toggle on match");
  a_cap_rise: assert property (
    src == SRC_RISE && !st.buf_en && pin_rise |-> s_captured)
    else $error("rising edge not captured");
  a_cap_fall: assert property (
    src == SRC_FALL && !st.buf_en && pin_fall |-> s_captured)
    else $error("falling edge not captured");
  a_cap_both: assert property (
    src == SRC_BOTH && !st.buf_en && (pin_rise || pin_fall)
      |-> s_captured)
    else $error("edge not captured in both edge mode");
  a_cap_ch4: assert property (
    src == SRC_CH4 && !st.buf_en && ch4_count_pulse_i |-> s_captured)
    else $error("channel 4 count step not captured");
  a_buf_hold_grc: assert property (
    st.buf_en && !(wr && hit_grc) |=> $stable(st.grc))
    else $error("register c changed while buffered");
  a_buf_hold_pin: assert property (
    st.buf_en && !wr_ctrl |=> $stable(ch3_pin_c_o))
    else $error("pin moved while buffered");
  a_cap_latch: assert property (
    cap_hit |-> s_captured)
    else $error("capture did not latch counter");

endmodule

// ### tb/pin_partner.sv
`timescale 1ns/1ps
// far side of pin c: drives the wire only while the block releases it
module pin_partner (
  // system
  input wire logic clk_i,
  // bench requests
  input wire logic lvl_i,
  input wire logic step_i,
  // block side
  input wire logic dut_o_i,
  input wire logic dut_oe_n_i,
  output logic pin_o,
  output logic count_pulse_o
);
  // wire level from both drivers; block wins while its enable is low
  assign pin_o = dut_oe_n_i ? lvl_i : dut_o_i;
  // registered so a step never lands on the edge that requested it
  always_ff @(posedge clk_i) begin
    count_pulse_o <= step_i;
  end
endmodule

// ### tb/compare_capture_pin_control_bench.sv
`timescale 1ns/1ps
module compare_capture_pin_control_bench;
  import compare_capture_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [WB_AW-1:0] adr = 8'h00;
  logic [WB_SW-1:0] sel = 4'h0;
  logic [WB_DW-1:0] wdat = 32'h0;
  logic [WB_DW-1:0] dat_o;
  logic [WB_DW-1:0] rdat;
  logic ack, pin_o, oe_n, irq, pin_in, pulse;
  logic lvl = 1'b0;
  logic step = 1'b0;
  logic [3:0] f;
  int mismatches = 0;
  int cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  // short counter so a second toggle match comes after 16 cycles
  compare_capture_pin_control #(.CNT_W(4)) compare_capture_pin_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ch3_pin_c_i(pin_in),
    .ch3_pin_c_o(pin_o), .ch3_pin_c_oe_n_o(oe_n),
    .ch4_count_pulse_i(pulse), .irq_o(irq));

  pin_partner pin_partner_inst (
    .clk_i(clk_i), .lvl_i(lvl), .step_i(step), .dut_o_i(pin_o),
    .dut_oe_n_i(oe_n), .pin_o(pin_in), .count_pulse_o(pulse));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ack and read data are taken at the rising edge that samples ack high,
  // and the request is released at that same edge, never earlier
  task access(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      mismatches++;
      results();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    check(irq, 1'b1);
    // a match that never comes ends the run here
    if (irq !== 1'b1) begin
      results();
    end
  endtask

  // k 0 rising pin, 1 falling pin, 2 channel 4 step
  task trig(input int k, input logic [31:0] exp);
    @(posedge clk_i);
    if (k == 2) begin
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
    end else begin
      lvl <= (k == 0);
    end
    repeat (3) @(negedge clk_i);
    rd(STAT_OFS, exp);
    wr(STAT_OFS, 32'h3);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(oe_n, 1'b1);
    check(irq, 1'b0);
    rd(CTRL_OFS, 32'h0);
    rd(PIN_OFS, 32'h2);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) begin
      f = 4'(i);
      wr(CTRL_OFS, 32'h0);
      wr(STAT_OFS, 32'h3);
      wr(GRC_OFS, 32'h9);
      wr(COUNT_OFS, 32'h0);
      wr(MASK_OFS, 32'h1);
      wr(CTRL_OFS, 32'(f) | 32'h20);
      @(negedge clk_i);
      check(oe_n, f[1:0] == 2'b00);
      if (f[1:0] != 2'b00) check(pin_o, f[2]);
      wait_irq();
      if (f[1:0] == 2'b01) check(pin_o, 1'b0);
      if (f[1:0] == 2'b10) check(pin_o, 1'b1);
      if (f[1:0] == 2'b11) begin
        // logical not keeps the expected level one bit wide
        check(pin_o, !f[2]);
        repeat (16) @(negedge clk_i);
        check(pin_o, f[2]);
      end
      wr(CTRL_OFS, 32'(f));
      rd(STAT_OFS, 32'h1);
      wr(STAT_OFS, 32'h1);
      rd(STAT_OFS, 32'h0);
      check(irq, 1'b0);
    end
    // buffer mode: matches pass by with no event
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h33);
    repeat (40) @(negedge clk_i);
    check(irq, 1'b0);
    check(pin_o, 1'b0);
    wr(CTRL_OFS, 32'h18);
    trig(0, 32'h0);
    trig(1, 32'h0);
    rd(GRC_OFS, 32'h9);
    // 101x is run with bit 0 both clear and set
    for (int i = 0; i < 5; i++) begin
      f = (i == 4) ? 4'hc : 4'(8 + i);
      wr(CTRL_OFS, 32'h0);
      wr(MASK_OFS, 32'h0);
      wr(COUNT_OFS, 32'(5 + i));
      wr(GRC_OFS, 32'h0);
      wr(STAT_OFS, 32'h3);
      wr(CTRL_OFS, 32'(f));
      @(negedge clk_i);
      check(oe_n, 1'b1);
      if (f == 4'h8) begin
        @(posedge clk_i);
        lvl <= 1'b1;
        repeat (3) @(negedge clk_i);
        check(irq, 1'b0);
        wr(MASK_OFS, 32'h2);
        @(negedge clk_i);
        check(irq, 1'b1);
        wr(STAT_OFS, 32'h3);
        @(negedge clk_i);
        check(irq, 1'b0);
        @(posedge clk_i);
        lvl <= 1'b0;
        repeat (3) @(negedge clk_i);
        wr(STAT_OFS, 32'h3);
        trig(0, 32'h2);
      end else begin
        trig(0, (f[2:1] == 2'b01) ? 32'h2 : 32'h0);
      end
      trig(1, (f == 4'h9 || f[2:1] == 2'b01) ? 32'h2 : 32'h0);
      trig(2, f[2] ? 32'h2 : 32'h0);
      rd(GRC_OFS, 32'(5 + i));
    end
    results();
  end
endmodule
